// ---- flash_bus_cycle.v ----
// One asynchronous flash bus cycle, read or write
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_consts.vh"
module flash_bus_cycle (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire wr,
  input wire [19:0] addr,
  input wire [15:0] wdata,
  input wire [15:0] dq_in,
  output reg done,
  output reg [15:0] rdata,
  output reg [19:0] a_out,
  output reg [15:0] dq_out,
  output reg dq_oe_n,
  output reg ce_n,
  output reg oe_n,
  output reg we_n
);
  reg [1:0] ph_q;
  reg [3:0] cnt_q;
  reg wr_q;
  wire [31:0] phase_last = `PHASE_CYC - 1;
  always @(posedge clk) begin
    done <= 1'b0;
    if (!rst_n) begin
      ph_q <= 2'h0;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      rdata <= 16'h0000;
      a_out <= 20'h00000;
      dq_out <= 16'h0000;
      dq_oe_n <= 1'b1;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
    end else begin
      case (ph_q)
        2'h0: if (start) begin
          wr_q <= wr;
          a_out <= addr;
          dq_out <= wdata;
          dq_oe_n <= ~wr;
          ce_n <= 1'b0;
          oe_n <= wr;
          we_n <= ~wr;
          cnt_q <= 4'h0;
          ph_q <= 2'h1;
        end
        2'h1: if (cnt_q == phase_last[3:0]) begin
          if (!wr_q) rdata <= dq_in;
          ce_n <= 1'b1;
          oe_n <= 1'b1;
          we_n <= 1'b1;
          cnt_q <= 4'h0;
          ph_q <= 2'h2;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
        2'h2: if (cnt_q == phase_last[3:0]) begin
          dq_oe_n <= 1'b1;
          done <= 1'b1;
          ph_q <= 2'h0;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
        default: ph_q <= 2'h0;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- flash_dev_model.sv ----
// Behavioural model of the flash device on the far side
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter int BUSY_READS = 4,
  parameter logic [7:0] PROT_PAGE = 8'h0c
) (
  input wire logic [19:0] a,
  input wire logic [15:0] dq_w,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic stuck,
  input wire logic hold_busy,
  output logic [15:0] dq_r,
  output logic ready_busy_out
);
  int left = 0;
  logic [15:0] pd = 16'hffff;
  logic erase = 1'b0;
  logic tgl = 1'b0;
  logic prog = 1'b0;
  logic pend = 1'b0;
  logic susp = 1'b0;
  logic armed = 1'b0;
  logic win = 1'b0;
  logic failed = 1'b0;
  wire logic wr_act = !ce_n && !we_n && oe_n;
  wire logic rd_act = !ce_n && !oe_n;
  initial dq_r = 16'h0000;
  // ==========================================
  // Ready/busy, pulled up when released
  assign ready_busy_out = !(hold_busy || failed || (left > 0 && !susp));
  // ==========================================
  // Command writes, latched when chip or write enable rises first
  always @(negedge wr_act) begin
    if (dq_w[7:0] == 8'hf0) begin
      failed = 1'b0;
      armed = 1'b0;
      prog = 1'b0;
    end else if ((left > 0 || failed) && !susp) begin
      if (win && dq_w[7:0] == 8'h30) begin
        left = BUSY_READS;
      end else if (erase && dq_w[7:0] == 8'hb0) begin
        if (win) susp = 1'b1;
        else pend = 1'b1;
        win = 1'b0;
        if (!susp) left = 2;
      end else if (win) begin
        win = 1'b0;
        erase = 1'b0;
        left = 0;
      end
    end else if (susp && dq_w[7:0] == 8'h30) begin
      susp = 1'b0;
      left = BUSY_READS;
    end else if (prog) begin
      prog = 1'b0;
      if (a[19:12] == PROT_PAGE) begin
        left = 1;
      end else begin
        pd = dq_w;
        erase = 1'b0;
        failed = stuck;
        left = stuck ? 0 : BUSY_READS;
      end
    end else if (dq_w[7:0] == 8'ha0) begin
      prog = 1'b1;
      armed = 1'b0;
    end else if (armed && (dq_w[7:0] == 8'h10 || dq_w[7:0] == 8'h30)) begin
      armed = 1'b0;
      if (dq_w[7:0] == 8'h30 && a[19:12] == PROT_PAGE) begin
        left = 1;
      end else begin
        erase = 1'b1;
        win = (dq_w[7:0] == 8'h30);
        left = BUSY_READS;
      end
    end else if (dq_w[7:0] == 8'h80) begin
      armed = 1'b1;
    end else if (dq_w[7:0] != 8'haa && dq_w[7:0] != 8'h55) begin
      armed = 1'b0;
    end
  end
  // ==========================================
  // Reads: status while busy, data after
  always @(posedge rd_act) begin
    if (left > 0 || failed) begin
      tgl = !tgl;
      dq_r = {8'ha5, erase ? 1'b0 : !pd[7], tgl, failed, 1'b0, erase && !win, 3'h2};
      win = 1'b0;
      if (!failed) left = left - 1;
      if (left == 0 && pend) begin
        susp = 1'b1;
        pend = 1'b0;
      end
    end else begin
      dq_r = erase ? 16'hffff : pd;
    end
  end
  always @(negedge rd_act) dq_r = ~dq_r;
endmodule
`default_nettype wire

// ---- flash_host_consts.vh ----
// Constants of the flash host controller
`ifndef FLASH_HOST_CONSTS_VH
`define FLASH_HOST_CONSTS_VH
// Command codes
`define CMD_UNLOCK1 8'haa
`define CMD_UNLOCK2 8'h55
`define CMD_PROGRAM 8'ha0
`define CMD_ERASE_SETUP 8'h80
`define CMD_CHIP_ERASE 8'h10
`define CMD_SECTOR_CONFIRM 8'h30
`define CMD_SUSPEND 8'hb0
`define CMD_RESUME 8'h30
`define CMD_READ_RESET 8'hf0
// Unlock addresses, word mode
`define ADDR_UNLOCK1 20'h05555
`define ADDR_UNLOCK2 20'h02aaa
// Status bit positions on the data bus
`define POLL_BIT 7
`define TOGGLE_BIT 6
`define FAIL_BIT 5
`define TIMER_BIT 3
// Bus cycle phase length in MCLK cycles, 120 ns at 40 ns
`define PHASE_NS 120
`define CLK_NS 40
`define PHASE_CYC ((`PHASE_NS + `CLK_NS - 1) / `CLK_NS)
// Operation kinds
`define OP_PROGRAM 3'h0
`define OP_CHIP_ERASE 3'h1
`define OP_SECTOR_ERASE 3'h2
`define OP_ADD_SECTOR 3'h3
`define OP_SUSPEND 3'h4
`define OP_RESUME 3'h5
`define OP_READ 3'h6
`define OP_RESET 3'h7
`endif

// ---- flash_host_ctrl.v ----
// Host controller for an asynchronous NOR flash: command sequences and status polling
// Summary of operation
// - Host polls suspend status at an address inside an erasing sector.
// - Polling bit may flip before lower bits settle; host rereads.
// - After timing failure, host issues read/reset before further operations; the controller leaves it to an OP_RESET request.
// - Host checks erase-timer bit before and after each added sector command.
// - Suspend code b0, resume code 30, valid only during sector erase.
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_consts.vh"
module flash_host_ctrl (
  input wire MCLK,
  input wire RESETN,
  input wire REQ,
  input wire [2:0] OP,
  input wire [19:0] ADDR,
  input wire [15:0] DATA,
  output reg BUSY,
  output reg DONE,
  output reg FAIL,
  output reg REJECTED,
  output reg [15:0] RDATA,
  output wire [19:0] FA,
  output wire [15:0] FDQ_OUT,
  output wire FDQ_OE_N,
  input wire [15:0] FDQ_IN,
  output wire FCE_N,
  output wire FOE_N,
  output wire FWE_N,
  input wire FRY_BY
);
  // ============================================================
  // States
  localparam S_IDLE = 4'h0;
  localparam S_WRITE = 4'h1;
  localparam S_WWAIT = 4'h2;
  localparam S_TCHK = 4'h3;
  localparam S_TWAIT = 4'h4;
  localparam S_POLL = 4'h5;
  localparam S_PWAIT = 4'h6;
  localparam S_READ = 4'h7;
  localparam S_RWAIT = 4'h8;
  localparam S_RECHK = 4'h9;
  localparam S_RCWAIT = 4'ha;
  localparam S_FIN = 4'hb;

  reg [3:0] st_q;
  reg [2:0] op_q;
  reg [19:0] addr_q;
  reg [15:0] data_q;
  reg [2:0] idx_q;
  reg [2:0] nwr_q;
  reg [15:0] prev_q;
  reg first_q;
  reg suspended_q;
  reg start_q;
  reg wr_q;
  reg [19:0] baddr_q;
  reg [15:0] bdata_q;
  wire bdone;
  wire [15:0] brdata;

  flash_bus_cycle u_cyc (
    .clk(MCLK),
    .rst_n(RESETN),
    .start(start_q),
    .wr(wr_q),
    .addr(baddr_q),
    .wdata(bdata_q),
    .dq_in(FDQ_IN),
    .done(bdone),
    .rdata(brdata),
    .a_out(FA),
    .dq_out(FDQ_OUT),
    .dq_oe_n(FDQ_OE_N),
    .ce_n(FCE_N),
    .oe_n(FOE_N),
    .we_n(FWE_N)
  );

  // ============================================================
  // Command sequence table
  reg [19:0] seq_a;
  reg [15:0] seq_d;
  always @* begin
    seq_a = addr_q;
    seq_d = data_q;
    case (idx_q)
      3'h0: begin seq_a = `ADDR_UNLOCK1; seq_d = {8'h00, `CMD_UNLOCK1}; end
      3'h1: begin seq_a = `ADDR_UNLOCK2; seq_d = {8'h00, `CMD_UNLOCK2}; end
      3'h2: begin
        seq_a = `ADDR_UNLOCK1;
        seq_d = {8'h00, (op_q == `OP_PROGRAM) ? `CMD_PROGRAM : `CMD_ERASE_SETUP};
      end
      3'h3: begin
        seq_a = (op_q == `OP_PROGRAM) ? addr_q : `ADDR_UNLOCK1;
        seq_d = (op_q == `OP_PROGRAM) ? data_q : {8'h00, `CMD_UNLOCK1};
      end
      3'h4: begin seq_a = `ADDR_UNLOCK2; seq_d = {8'h00, `CMD_UNLOCK2}; end
      default: begin
        seq_a = (op_q == `OP_CHIP_ERASE) ? `ADDR_UNLOCK1 : addr_q;
        seq_d = {8'h00, (op_q == `OP_CHIP_ERASE) ? `CMD_CHIP_ERASE : `CMD_SECTOR_CONFIRM};
      end
    endcase
    if (nwr_q == 3'h1) begin
      // Single-write commands: address is a don't-care
      seq_a = addr_q;
      case (op_q)
        `OP_SUSPEND: seq_d = {8'h00, `CMD_SUSPEND};
        `OP_RESUME: seq_d = {8'h00, `CMD_RESUME};
        `OP_ADD_SECTOR: seq_d = {8'h00, `CMD_SECTOR_CONFIRM};
        default: seq_d = {8'h00, `CMD_READ_RESET};
      endcase
    end
  end

  // ============================================================
  // Sequencer
  wire toggling = (brdata[`TOGGLE_BIT] != prev_q[`TOGGLE_BIT]);
  always @(posedge MCLK) begin
    start_q <= 1'b0;
    DONE <= 1'b0;
    if (!RESETN) begin
      st_q <= S_IDLE;
      op_q <= 3'h0;
      addr_q <= 20'h00000;
      data_q <= 16'h0000;
      idx_q <= 3'h0;
      nwr_q <= 3'h0;
      prev_q <= 16'h0000;
      first_q <= 1'b0;
      suspended_q <= 1'b0;
      wr_q <= 1'b0;
      baddr_q <= 20'h00000;
      bdata_q <= 16'h0000;
      BUSY <= 1'b0;
      FAIL <= 1'b0;
      REJECTED <= 1'b0;
      RDATA <= 16'h0000;
    end else begin
      case (st_q)
        S_IDLE: if (REQ) begin
          op_q <= OP;
          addr_q <= ADDR;
          data_q <= DATA;
          idx_q <= 3'h0;
          BUSY <= 1'b1;
          FAIL <= 1'b0;
          REJECTED <= 1'b0;
          first_q <= 1'b1;
          case (OP)
            `OP_PROGRAM: nwr_q <= 3'h4;
            `OP_CHIP_ERASE, `OP_SECTOR_ERASE: nwr_q <= 3'h6;
            `OP_READ: nwr_q <= 3'h0;
            default: nwr_q <= 3'h1;
          endcase
          if (OP == `OP_READ) st_q <= S_READ;
          else if (OP == `OP_ADD_SECTOR) st_q <= S_TCHK;
          else if (!FRY_BY && (OP == `OP_PROGRAM || OP == `OP_CHIP_ERASE || OP == `OP_SECTOR_ERASE)) begin
            // Busy device refuses program and erase; reset stays allowed
            REJECTED <= 1'b1;
            st_q <= S_FIN;
          end else st_q <= S_WRITE;
        end
        S_TCHK: begin
          // Timer bit checked before and after the added sector write
          wr_q <= 1'b0;
          baddr_q <= addr_q;
          start_q <= 1'b1;
          st_q <= S_TWAIT;
        end
        S_TWAIT: if (bdone) begin
          if (brdata[`TIMER_BIT]) begin
            REJECTED <= 1'b1;
            st_q <= S_FIN;
          end else if (first_q) begin
            first_q <= 1'b0;
            st_q <= S_WRITE;
          end else begin
            prev_q <= brdata;
            st_q <= S_POLL;
          end
        end
        S_WRITE: begin
          wr_q <= 1'b1;
          baddr_q <= seq_a;
          bdata_q <= seq_d;
          start_q <= 1'b1;
          st_q <= S_WWAIT;
        end
        S_WWAIT: if (bdone) begin
          if (idx_q + 3'h1 != nwr_q) begin
            idx_q <= idx_q + 3'h1;
            st_q <= S_WRITE;
          end else if (op_q == `OP_ADD_SECTOR) begin
            st_q <= S_TCHK;
          end else if (op_q == `OP_RESET || op_q == `OP_RESUME) begin
            if (op_q == `OP_RESUME) suspended_q <= 1'b0;
            st_q <= S_FIN;
          end else begin
            first_q <= 1'b1;
            st_q <= S_POLL;
          end
        end
        S_POLL: begin
          // Status read at the operation address, an erasing sector when erasing
          wr_q <= 1'b0;
          baddr_q <= addr_q;
          start_q <= 1'b1;
          st_q <= S_PWAIT;
        end
        S_PWAIT: if (bdone) begin
          prev_q <= brdata;
          if (first_q) begin
            first_q <= 1'b0;
            st_q <= S_POLL;
          end else if (!toggling) begin
            // Toggle stopped: done, suspended or protected no-op
            if (op_q == `OP_SUSPEND) suspended_q <= 1'b1;
            st_q <= S_RECHK;
          end else if (brdata[`FAIL_BIT]) begin
            // Recheck toggle after the failure bit rises
            st_q <= S_RECHK;
          end else begin
            st_q <= S_POLL;
          end
        end
        S_RECHK: begin
          wr_q <= 1'b0;
          baddr_q <= addr_q;
          start_q <= 1'b1;
          st_q <= S_RCWAIT;
        end
        S_RCWAIT: if (bdone) begin
          if (brdata[`TOGGLE_BIT] != prev_q[`TOGGLE_BIT]) begin
            FAIL <= 1'b1;
          end else if (op_q == `OP_PROGRAM && brdata[`POLL_BIT] != data_q[`POLL_BIT]) begin
            FAIL <= 1'b1;
          end else if ((op_q == `OP_CHIP_ERASE || op_q == `OP_SECTOR_ERASE) && !brdata[`POLL_BIT]) begin
            FAIL <= 1'b1;
          end
          RDATA <= brdata;
          st_q <= S_FIN;
        end
        S_READ: begin
          wr_q <= 1'b0;
          baddr_q <= addr_q;
          start_q <= 1'b1;
          st_q <= S_RWAIT;
        end
        S_RWAIT: if (bdone) begin
          RDATA <= brdata;
          st_q <= S_FIN;
        end
        S_FIN: begin
          BUSY <= 1'b0;
          DONE <= 1'b1;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- flash_host_ctrl_properties.sv ----
// Port checker for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl_properties (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic REQ,
  input wire logic [2:0] OP,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic REJECTED,
  input wire logic [19:0] FA,
  input wire logic [15:0] FDQ_OUT,
  input wire logic FDQ_OE_N,
  input wire logic FCE_N,
  input wire logic FOE_N,
  input wire logic FWE_N,
  input wire logic FRY_BY
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  wire take = REQ && !BUSY;
  sequence s_wr_pulse;
    !FWE_N[*3] ##1 FWE_N;
  endsequence
  sequence s_rd_pulse;
    (!FOE_N && FDQ_OE_N)[*3] ##1 FOE_N;
  endsequence
  a_done_pulse: assert property (DONE |=> !DONE) else $error("done pulse too long");
  a_done_idle: assert property (DONE |-> !BUSY && FCE_N && FOE_N && FWE_N) else $error("pins busy at done");
  a_req_taken: assert property (take |=> BUSY) else $error("request not taken");
  a_write_pulse: assert property ($fell(FWE_N) |-> s_wr_pulse) else $error("write strobe length");
  a_write_drive: assert property (!FWE_N |-> !FCE_N && FOE_N && !FDQ_OE_N) else $error("write drive");
  a_read_pulse: assert property ($fell(FOE_N) |-> s_rd_pulse) else $error("read strobe length");
  a_addr_hold: assert property (!FWE_N && !$past(FWE_N) |-> $stable(FA) && $stable(FDQ_OUT))
    else $error("address moved in write");
  a_refuse_write: assert property (take && !FRY_BY && OP <= 3'h2 |=> FWE_N[*4])
    else $error("write while busy");
  a_refuse_flag: assert property (take && !FRY_BY && OP <= 3'h2 |-> ##[1:8] (DONE && REJECTED))
    else $error("busy op not rejected");
  a_suspend_code: assert property (take && OP == 3'h4 |-> ##[2:8] ($fell(FWE_N) && FDQ_OUT[7:0] == 8'hb0))
    else $error("suspend code");
  a_resume_code: assert property (take && OP == 3'h5 && FRY_BY |-> ##[2:8] ($fell(FWE_N) && FDQ_OUT[7:0] == 8'h30))
    else $error("resume code");
endmodule
bind flash_host_ctrl flash_host_ctrl_properties u_props (.MCLK(MCLK), .RESETN(RESETN), .REQ(REQ), .OP(OP),
  .BUSY(BUSY), .DONE(DONE), .REJECTED(REJECTED), .FA(FA), .FDQ_OUT(FDQ_OUT), .FDQ_OE_N(FDQ_OE_N),
  .FCE_N(FCE_N), .FOE_N(FOE_N), .FWE_N(FWE_N), .FRY_BY(FRY_BY));
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking testbench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic req = 1'b0;
  logic [2:0] op = 3'h0;
  logic [19:0] addr = 20'h00000;
  logic [15:0] data = 16'h0000;
  logic stuck = 1'b0;
  logic hold_busy = 1'b0;
  wire logic busy, done, fail, rejected, fdq_oe_n, fce_n, foe_n, fwe_n, fry_by;
  wire logic [15:0] rdata, fdq_out, fdq_in;
  wire logic [19:0] fa;
  int failures = 0;
  int check_count = 0;
  initial forever #20 mclk = ~mclk;
  flash_host_ctrl u_dut (.MCLK(mclk), .RESETN(resetn), .REQ(req), .OP(op), .ADDR(addr), .DATA(data),
    .BUSY(busy), .DONE(done), .FAIL(fail), .REJECTED(rejected), .RDATA(rdata), .FA(fa), .FDQ_OUT(fdq_out),
    .FDQ_OE_N(fdq_oe_n), .FDQ_IN(fdq_in), .FCE_N(fce_n), .FOE_N(foe_n), .FWE_N(fwe_n), .FRY_BY(fry_by));
  flash_dev_model u_flash (.a(fa), .dq_w(fdq_out), .ce_n(fce_n), .oe_n(foe_n), .we_n(fwe_n), .stuck(stuck),
    .hold_busy(hold_busy), .dq_r(fdq_in), .ready_busy_out(fry_by));
  // ==========================================
  // Shared tasks
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic run_op(input logic [2:0] o, input logic [19:0] a, input logic [15:0] d);
    int n;
    @(posedge mclk);
    #1 op = o;
    addr = a;
    data = d;
    req = 1'b1;
    @(posedge mclk);
    #1 req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      #1 n++;
    end
    chk("done", 16'h1, {15'h0, done});
  endtask
  // ==========================================
  // Scenarios
  task automatic t_program;
    logic [15:0] v[2] = '{16'h1234, 16'h00a5};
    foreach (v[i]) begin
      run_op(3'h0, 20'h01000, v[i]);
      chk("program fail", 16'h0, {15'h0, fail});
      chk("program data", v[i], rdata);
      run_op(3'h6, 20'h01000, 16'h0000);
      chk("read back", v[i], rdata);
    end
    run_op(3'h0, 20'h0c010, 16'h0000);
    chk("protected program fail", 16'h1, {15'h0, fail});
    run_op(3'h6, 20'h0c010, 16'h0000);
    chk("protected program data", 16'h00a5, rdata);
    $display("test program done");
  endtask
  task automatic t_erase;
    run_op(3'h1, 20'h00000, 16'h0000);
    chk("chip erase data", 16'hffff, rdata);
    run_op(3'h2, 20'h04000, 16'h0000);
    chk("sector erase fail", 16'h0, {15'h0, fail});
    run_op(3'h2, 20'h0c000, 16'h0000);
    chk("protected erase fail", 16'h0, {15'h0, fail});
    chk("protected erase data", 16'hffff, rdata);
    run_op(3'h3, 20'h08000, 16'h0000);
    chk("late add sector", 16'h1, {15'h0, rejected});
    $display("test erase done");
  endtask
  task automatic t_busy;
    hold_busy = 1'b1;
    run_op(3'h0, 20'h01000, 16'h0f0f);
    chk("program while busy", 16'h1, {15'h0, rejected});
    run_op(3'h4, 20'h04000, 16'h0000);
    chk("suspend while busy", 16'h0, {15'h0, rejected});
    hold_busy = 1'b0;
    run_op(3'h5, 20'h00000, 16'h0000);
    chk("resume", 16'h0, {15'h0, rejected});
    $display("test busy done");
  endtask
  task automatic t_fail;
    stuck = 1'b1;
    run_op(3'h0, 20'h02000, 16'h0055);
    chk("overrun fail", 16'h1, {15'h0, fail});
    run_op(3'h0, 20'h03000, 16'h0011);
    chk("program while failed", 16'h1, {15'h0, rejected});
    run_op(3'h7, 20'h00000, 16'h0000);
    chk("reset accepted", 16'h0, {15'h0, rejected});
    stuck = 1'b0;
    run_op(3'h0, 20'h03000, 16'h0077);
    chk("after reset fail", 16'h0, {15'h0, fail});
    chk("after reset data", 16'h0077, rdata);
    $display("test fail done");
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    #1 resetn = 1'b1;
    t_program;
    t_erase;
    t_busy;
    t_fail;
    end_sim;
  end
  initial begin
    #(40 * 60000);
    failures++;
    end_sim;
  end
endmodule
`default_nettype wire
